/* File: core/fxo_exc_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fxo_map.svh"
// Behaviour
// - an operand error without an overflow on the same op, and with no posted exception pending, sets the operand error flag in the status byte
// - masked operand error, handler off, fp register destination: store all-ones quiet nan, no exception
// - handler on, fp register destination: keep destination, post, pre-instruction exception at next op
// - integer move of too large, nan or infinite source: immediate post exception
// - integer move of the most negative integer also traps post-instruction
// - saved command field names the instruction that trapped
// - memory destination: effective address goes to the exception frame
// - integer register destination: address register points at opcode word
// - overflow when rounded exponent reaches precision maximum
// - overflow only for single, double, extended; else operand error
// - order: underflow check, round, overflow check, then store
// - overflow sets the overflow flag in the status byte
// - overflow judged on the precision-rounded value, kept as extended
// - overflow exception is always taken, never masked
// - overflow into fp register keeps it, pre or post reporting
// - overflow into memory or integer register stores junk, immediate post
// - replacement per rounding mode: infinity or largest magnitude by sign
// - overflow rounding precision: control register, or format, forced wins
module fxo_exc_unit (
   // clock and reset
   input  wire logic            sys_clk,
   input  wire logic            rstn,
   input  wire logic            clk_en,
   // instruction issue
   input  wire logic            op_valid,
   input  wire logic [15:0]     op_cmd,
   input  wire logic [31:0]     op_iaddr,
   input  wire logic [31:0]     op_ea,
   input  wire fxo_pkg::fxo_dst_e op_dst,
   input  wire logic [2:0]      op_fmt,
   input  wire logic            op_is_int_move,
   input  wire logic            op_can_overflow_flag,
   input  wire logic            op_forced_prec,
   input  wire logic [1:0]      op_prec,
   // datapath inputs
   input  wire fxo_pkg::fxo_ext_s op_inter,
   input  wire logic            op_src_nan,
   input  wire logic            op_src_inf,
   input  wire logic            op_int_too_big,
   input  wire logic            op_int_most_neg,
   input  wire logic            op_arith_operand_error_flag,
   // control register bits and exception acknowledge
   input  wire logic [1:0]      ctl_prec,
   input  wire logic [1:0]      ctl_mode,
   input  wire logic            ctl_operand_error_flag_en,
   input  wire logic            ctl_post_overflow_flag_fpreg,
   input  wire logic            exc_ack,
   // result
   output logic                 wr_valid,
   output logic                 wr_undefined,
   output fxo_pkg::fxo_ext_s    wr_data,
   // status byte and exception report
   output logic [7:0]           exception_status_byte,
   output logic                 underflow_seen,
   output logic                 exc_req,
   output fxo_pkg::fxo_kind_e   exc_kind,
   output logic                 exc_operand_error_flag,
   output logic                 exc_overflow_flag,
   output logic                 exc_ea_valid,
   output logic [15:0]          saved_command_field,
   output logic [31:0]          exc_ea,
   output logic [31:0]          fp_instruction_address_register
);
   import fxo_pkg::*;

   typedef struct packed {
      logic       wr_valid;
      logic       wr_undef;
      fxo_ext_s   wr_data;
      logic [7:0] status;
      logic       unfl;
      logic       req;
      fxo_kind_e  kind;
      logic       operand_error_flag;
      logic       overflow_flag;
      logic       ea_valid;
      logic [15:0] cmd;
      logic [31:0] ea;
      logic [31:0] iaddr;
      logic       pend;
      logic       pend_overflow_flag;
      logic [15:0] pend_cmd;
      logic [31:0] pend_iaddr;
   } fxo_state_s;

   fxo_state_s st_r;
   fxo_state_s st_nxt;

   function automatic logic fmt_is_float(input logic [2:0] f);
      fmt_is_float = f == `FXO_FMT_SGL || f == `FXO_FMT_DBL || f == `FXO_FMT_EXT;
   endfunction

   function automatic logic [1:0] fmt_prec(input logic [2:0] f);
      case (f)
         `FXO_FMT_SGL: fmt_prec = `FXO_PREC_SGL;
         `FXO_FMT_DBL: fmt_prec = `FXO_PREC_DBL;
         default:      fmt_prec = `FXO_PREC_EXT;
      endcase
   endfunction

   function automatic fxo_ext_s largest(input logic s, input logic [1:0] p);
      logic [14:0] em;
      begin
         case (p)
            `FXO_PREC_SGL: em = `FXO_EMAX_SGL;
            `FXO_PREC_DBL: em = `FXO_EMAX_DBL;
            default:       em = `FXO_EMAX_EXT;
         endcase
         largest.sign = s;
         largest.exp  = em - 15'h1;
         case (p)
            `FXO_PREC_SGL: largest.mant = {24'hffffff, 40'h0};
            `FXO_PREC_DBL: largest.mant = {53'h1fffffffffffff, 11'h0};
            default:       largest.mant = 64'hffffffffffffffff;
         endcase
      end
   endfunction

   function automatic fxo_ext_s infinity(input logic s);
      infinity.sign = s;
      infinity.exp  = `FXO_EMAX_EXT;
      infinity.mant = 64'h0;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // rounding stage

   fxo_round_if rif ();
   logic [1:0]  sel_prec;
   logic        dst_float;
   logic        overflow_flag_det;
   logic        operand_error_flag_det;
   logic        int_trap;

   always_comb begin
      // forced precision beats both other sources
      if (op_forced_prec) begin
         sel_prec = op_prec;
      end else if (op_dst == FXO_DST_FPREG) begin
         sel_prec = ctl_prec;
      end else begin
         sel_prec = fmt_prec(op_fmt);
      end
   end

   assign rif.inter = op_inter;
   assign rif.prec  = sel_prec;
   assign rif.mode  = ctl_mode;

   fxo_rounder u_rnd (
      .rif (rif)
   );

   always_comb begin
      dst_float = op_dst == FXO_DST_FPREG || fmt_is_float(op_fmt);
      // conversions to integer: trap on bad source or most-negative value
      int_trap  = op_is_int_move &&
                  (op_int_too_big || op_src_nan || op_src_inf || op_int_most_neg);
      // overflow into a non-float format becomes an operand error
      overflow_flag_det  = op_can_overflow_flag && rif.overflow_flag && dst_float;
      operand_error_flag_det = op_arith_operand_error_flag || int_trap ||
                  (op_can_overflow_flag && rif.overflow_flag && !dst_float);
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_nxt          = st_r;
      st_nxt.wr_valid = 1'b0;
      st_nxt.wr_undef = 1'b0;
      // request holds until acknowledged
      if (exc_ack) begin
         st_nxt.req = 1'b0;
      end
      if (op_valid && !st_r.req) begin
         st_nxt.status = 8'h0;
         st_nxt.unfl   = op_can_overflow_flag && rif.tiny;
         if (st_r.pend) begin
            // posted exception is reported at the next fp instruction
            st_nxt.pend     = 1'b0;
            st_nxt.req      = 1'b1;
            st_nxt.kind     = FXO_EXC_PRE;
            st_nxt.operand_error_flag    = !st_r.pend_overflow_flag;
            st_nxt.overflow_flag     = st_r.pend_overflow_flag;
            st_nxt.ea_valid = 1'b0;
            st_nxt.cmd      = st_r.pend_cmd;
            st_nxt.iaddr    = st_r.pend_iaddr;
            st_nxt.status   = st_r.status;
         end else if (overflow_flag_det) begin
            st_nxt.status[`FXO_EXC_OVERFLOW_FLAG_BIT] = 1'b1;
            st_nxt.cmd   = op_cmd;
            st_nxt.iaddr = op_iaddr;
            if (op_dst == FXO_DST_FPREG) begin
               // register untouched, report now or at next instruction
               if (ctl_post_overflow_flag_fpreg) begin
                  st_nxt.req      = 1'b1;
                  st_nxt.kind     = FXO_EXC_POST;
                  st_nxt.operand_error_flag    = 1'b0;
                  st_nxt.overflow_flag     = 1'b1;
                  st_nxt.ea_valid = 1'b0;
               end else begin
                  st_nxt.pend       = 1'b1;
                  st_nxt.pend_overflow_flag  = 1'b1;
                  st_nxt.pend_cmd   = op_cmd;
                  st_nxt.pend_iaddr = op_iaddr;
               end
            end else begin
               // undefined store then immediate post trap; value is the mode default
               st_nxt.wr_valid = 1'b1;
               st_nxt.wr_undef = 1'b1;
               case (ctl_mode)
                  `FXO_RND_ZERO:  st_nxt.wr_data = largest(rif.neg, sel_prec);
                  `FXO_RND_MINUS: st_nxt.wr_data = rif.neg ? infinity(1'b1)
                                                           : largest(1'b0, sel_prec);
                  `FXO_RND_PLUS:  st_nxt.wr_data = rif.neg ? largest(1'b1, sel_prec)
                                                           : infinity(1'b0);
                  default:        st_nxt.wr_data = infinity(rif.neg);
               endcase
               st_nxt.req      = 1'b1;
               st_nxt.kind     = FXO_EXC_POST;
               st_nxt.operand_error_flag    = 1'b0;
               st_nxt.overflow_flag     = 1'b1;
               st_nxt.ea_valid = op_dst == FXO_DST_MEM;
               st_nxt.ea       = op_ea;
               st_nxt.iaddr    = op_iaddr;
            end
         end else if (operand_error_flag_det) begin
            st_nxt.status[`FXO_EXC_OPERAND_ERROR_FLAG_BIT] = 1'b1;
            if (int_trap || op_dst != FXO_DST_FPREG) begin
               st_nxt.req      = 1'b1;
               st_nxt.kind     = FXO_EXC_POST;
               st_nxt.operand_error_flag    = 1'b1;
               st_nxt.overflow_flag     = 1'b0;
               st_nxt.cmd      = op_cmd;
               st_nxt.ea_valid = op_dst == FXO_DST_MEM;
               st_nxt.ea       = op_ea;
               st_nxt.iaddr    = op_iaddr;
            end else if (!ctl_operand_error_flag_en) begin
               st_nxt.wr_valid     = 1'b1;
               st_nxt.wr_data.sign = 1'b0;
               st_nxt.wr_data.exp  = `FXO_QNAN_EXP;
               st_nxt.wr_data.mant = `FXO_QNAN_MANT;
            end else begin
               st_nxt.pend       = 1'b1;
               st_nxt.pend_overflow_flag  = 1'b0;
               st_nxt.pend_cmd   = op_cmd;
               st_nxt.pend_iaddr = op_iaddr;
            end
         end else begin
            // clean result, kept in extended format
            st_nxt.wr_valid = 1'b1;
            st_nxt.wr_data  = rif.rounded;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign wr_valid                        = st_r.wr_valid;
   assign wr_undefined                    = st_r.wr_undef;
   assign wr_data                         = st_r.wr_data;
   assign exception_status_byte           = st_r.status;
   assign underflow_seen                  = st_r.unfl;
   assign exc_req                         = st_r.req;
   assign exc_kind                        = st_r.kind;
   assign exc_operand_error_flag                       = st_r.operand_error_flag;
   assign exc_overflow_flag                        = st_r.overflow_flag;
   assign exc_ea_valid                    = st_r.ea_valid;
   assign saved_command_field             = st_r.cmd;
   assign exc_ea                          = st_r.ea;
   assign fp_instruction_address_register = st_r.iaddr;
endmodule
`default_nettype wire

/* File: core/fxo_map.svh */
`ifndef FXO_MAP_SVH
`define FXO_MAP_SVH
// exception status byte bit positions
`define FXO_EXC_OPERAND_ERROR_FLAG_BIT   5
`define FXO_EXC_OVERFLOW_FLAG_BIT    4
// rounding precision codes
`define FXO_PREC_EXT        2'h0
`define FXO_PREC_SGL        2'h1
`define FXO_PREC_DBL        2'h2
// rounding mode codes
`define FXO_RND_NEAREST     2'h0
`define FXO_RND_ZERO        2'h1
`define FXO_RND_MINUS       2'h2
`define FXO_RND_PLUS        2'h3
// destination formats
`define FXO_FMT_LONG        3'h0
`define FXO_FMT_SGL         3'h1
`define FXO_FMT_EXT         3'h2
`define FXO_FMT_PACKED      3'h3
`define FXO_FMT_WORD        3'h4
`define FXO_FMT_DBL         3'h5
`define FXO_FMT_BYTE        3'h6
// biased maximum exponents, extended bias
`define FXO_EMAX_EXT        15'h7fff
`define FXO_EMAX_SGL        15'h407f
`define FXO_EMAX_DBL        15'h43ff
`define FXO_BIAS_EXT        15'h3fff
// extended-precision quiet nan, all mantissa ones
`define FXO_QNAN_EXP        15'h7fff
`define FXO_QNAN_MANT       64'hffffffffffffffff
`endif

/* File: core/fxo_pkg.sv */
package fxo_pkg;
   typedef enum logic [1:0] {FXO_DST_FPREG, FXO_DST_MEM, FXO_DST_DREG} fxo_dst_e;
   typedef enum logic [1:0] {FXO_EXC_NONE, FXO_EXC_PRE, FXO_EXC_POST} fxo_kind_e;
   typedef struct packed {
      logic        sign;
      logic [14:0] exp;
      logic [63:0] mant;
   } fxo_ext_s;
endpackage

/* File: core/fxo_round_if.sv */
`timescale 1ns/1ps
`default_nettype none
// rounding stage signals shared between the checker and the rounder
interface fxo_round_if;
   import fxo_pkg::*;
   fxo_ext_s   inter;
   logic [1:0] prec;
   logic [1:0] mode;
   fxo_ext_s   rounded;
   logic       tiny;
   logic       overflow_flag;
   logic       neg;
   modport ctl (output inter, output prec, output mode,
                input rounded, input tiny, input overflow_flag, input neg);
   modport rnd (input inter, input prec, input mode,
                output rounded, output tiny, output overflow_flag, output neg);
endinterface
`default_nettype wire

/* File: core/fxo_rounder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fxo_map.svh"
// combinational: underflow check, round to precision, overflow check
module fxo_rounder (
   fxo_round_if.rnd rif
);
   import fxo_pkg::*;

   function automatic logic [14:0] emax_of(input logic [1:0] p);
      case (p)
         `FXO_PREC_SGL: emax_of = `FXO_EMAX_SGL;
         `FXO_PREC_DBL: emax_of = `FXO_EMAX_DBL;
         default:       emax_of = `FXO_EMAX_EXT;
      endcase
   endfunction

   function automatic logic [6:0] lsb_of(input logic [1:0] p);
      case (p)
         `FXO_PREC_SGL: lsb_of = 7'd40;
         `FXO_PREC_DBL: lsb_of = 7'd11;
         default:       lsb_of = 7'd0;
      endcase
   endfunction

   logic [64:0] sum;
   logic [63:0] keep;
   logic [63:0] below;
   logic [63:0] one;
   logic        up;
   logic [15:0] e1;

   always_comb begin
      keep  = '1 << lsb_of(rif.prec);
      below = ~keep & rif.inter.mant;
      one   = 64'h1 << lsb_of(rif.prec);
      case (rif.mode)
         `FXO_RND_NEAREST: up = below >= (one >> 1) && below != 64'h0;
         `FXO_RND_MINUS:   up = rif.inter.sign && below != 64'h0;
         `FXO_RND_PLUS:    up = !rif.inter.sign && below != 64'h0;
         default:          up = 1'b0;
      endcase
      sum = {1'b0, rif.inter.mant & keep} + (up ? {1'b0, one} : 65'h0);
      e1  = {1'b0, rif.inter.exp} + {15'h0, sum[64]};
      rif.rounded.sign = rif.inter.sign;
      rif.rounded.exp  = e1[14:0];
      rif.rounded.mant = sum[64] ? {1'b1, sum[63:1]} : sum[63:0];
      // underflow checked on the unrounded value, before rounding
      rif.tiny = rif.inter.exp == 15'h0;
      // overflow judged after rounding to the selected precision
      rif.overflow_flag = e1 >= {1'b0, emax_of(rif.prec)};
      rif.neg  = rif.inter.sign;
   end
endmodule
`default_nettype wire

/* File: tb/fxo_exc_props.sv */
`timescale 1ns/1ps
`default_nettype none
module fxo_exc_props
   import fxo_pkg::*;
(
   // clock and reset
   input wire logic                 sys_clk,
   input wire logic                 rstn,
   input wire logic                 clk_en,
   // issue
   input wire logic                 op_valid,
   input wire logic [15:0]          op_cmd,
   input wire logic [31:0]          op_iaddr,
   input wire logic [31:0]          op_ea,
   input wire fxo_pkg::fxo_dst_e    op_dst,
   input wire logic [2:0]           op_fmt,
   input wire logic                 op_is_int_move,
   input wire logic                 op_can_overflow_flag,
   input wire logic                 op_forced_prec,
   input wire fxo_pkg::fxo_ext_s    op_inter,
   input wire logic                 op_src_nan,
   input wire logic                 op_src_inf,
   input wire logic                 op_int_too_big,
   input wire logic                 op_int_most_neg,
   input wire logic                 op_arith_operand_error_flag,
   input wire logic [1:0]           ctl_prec,
   input wire logic                 ctl_operand_error_flag_en,
   input wire logic                 ctl_post_overflow_flag_fpreg,
   // results
   input wire logic                 wr_valid,
   input wire logic                 wr_undefined,
   input wire fxo_pkg::fxo_ext_s    wr_data,
   input wire logic [7:0]           exception_status_byte,
   input wire logic                 exc_req,
   input wire fxo_pkg::fxo_kind_e   exc_kind,
   input wire logic                 exc_operand_error_flag,
   input wire logic                 exc_overflow_flag,
   input wire logic                 exc_ea_valid,
   input wire logic [15:0]          saved_command_field,
   input wire logic [31:0]          exc_ea,
   input wire logic [31:0]          fp_instruction_address_register
);
   logic tk, tn, tk_d_r, pend_r, pend;
   // pending tracked here so a posted fault's pre report is not misread
   assign tk = clk_en & op_valid & ~exc_req;
   assign pend = tk_d_r ? (|exception_status_byte[5:4] & ~exc_req & ~wr_valid) : pend_r;
   assign tn = tk & ~pend;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tk_d_r <= 1'b0;
         pend_r <= 1'b0;
      end else begin
         tk_d_r <= tk;
         pend_r <= pend;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////////
   property p_operand_error_flag_flag;
      tn && op_arith_operand_error_flag && !op_can_overflow_flag |=> exception_status_byte[5];
   endproperty
   a_operand_error_flag_flag: assert property (p_operand_error_flag_flag) else $error("operand flag missing");
   property p_qnan;
      tn && op_arith_operand_error_flag && !op_can_overflow_flag && !op_is_int_move && !ctl_operand_error_flag_en
         && op_dst == FXO_DST_FPREG |=> wr_valid && !exc_req && wr_data.exp == 15'h7fff
         && (&wr_data.mant);
   endproperty
   a_qnan: assert property (p_qnan) else $error("quiet nan not stored");
   property p_pend_pre;
      tk && pend |=> exc_req && exc_kind == FXO_EXC_PRE && !wr_valid;
   endproperty
   a_pend_pre: assert property (p_pend_pre) else $error("posted fault not raised");
   property p_int_post;
      tn && op_is_int_move && !op_can_overflow_flag
         && (op_int_too_big | op_src_nan | op_src_inf | op_int_most_neg)
         |=> exc_req && exc_kind == FXO_EXC_POST && exc_operand_error_flag;
   endproperty
   a_int_post: assert property (p_int_post) else $error("integer move no trap");
   property p_frame;
      tn ##1 exc_req |-> saved_command_field == $past(op_cmd)
         && fp_instruction_address_register == $past(op_iaddr);
   endproperty
   a_frame: assert property (p_frame) else $error("frame fields wrong");
   property p_ea;
      tn && op_dst == FXO_DST_MEM ##1 exc_req |-> exc_ea_valid && exc_ea == $past(op_ea);
   endproperty
   a_ea: assert property (p_ea) else $error("address not saved");
   sequence s_sgl_big;
      tn && op_can_overflow_flag && !op_arith_operand_error_flag && !op_forced_prec && op_inter.exp >= 15'h407f;
   endsequence
   property p_overflow_flag_mem;
      s_sgl_big and op_dst == FXO_DST_MEM && op_fmt == 3'h1 |=> exc_req && exc_overflow_flag
         && exception_status_byte[4] && exc_kind == FXO_EXC_POST && wr_undefined;
   endproperty
   a_overflow_flag_mem: assert property (p_overflow_flag_mem) else $error("memory overflow");
   property p_overflow_flag_reg;
      s_sgl_big and op_dst == FXO_DST_FPREG && ctl_prec == 2'h1 && ctl_post_overflow_flag_fpreg
         |=> exc_req && exc_overflow_flag && !wr_valid && !wr_undefined;
   endproperty
   a_overflow_flag_reg: assert property (p_overflow_flag_reg) else $error("register overflow");
   property p_fmt_operand_error_flag;
      tn && op_can_overflow_flag && op_dst == FXO_DST_MEM && op_fmt == 3'h4 && op_inter.exp == 15'h7fff
         |=> exc_operand_error_flag && !exc_overflow_flag && exception_status_byte[5:4] == 2'h2;
   endproperty
   a_fmt_operand_error_flag: assert property (p_fmt_operand_error_flag) else $error("integer overflow kind");
   c_pend: cover property (tk && pend);
   c_overflow_flag: cover property (exc_req && exc_overflow_flag && exc_kind == FXO_EXC_POST);
   c_qnan: cover property (wr_valid && exception_status_byte[5]);
endmodule
bind fxo_exc_unit fxo_exc_props i_props (.*);
`default_nettype wire

/* File: tb/fxo_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none
// exception sequencer: acknowledges a request dly+1 cycles after it rises
module fxo_seq_model (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   // handshake
   input  wire logic       exc_req,
   input  wire logic [3:0] dly,
   output logic            exc_ack
);
   logic [3:0] cnt_r;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 4'h0;
         exc_ack <= 1'b0;
      end else begin
         // one-cycle pulse; request drop lags it by one edge
         exc_ack <= exc_req && !exc_ack && cnt_r == dly;
         cnt_r <= (exc_req && !exc_ack && cnt_r != dly) ? cnt_r + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fxo_pkg::*;
   typedef struct packed {
      logic [15:0] cmd;
      logic [31:0] ia, ea;
      fxo_dst_e    dst;
      logic [2:0]  fmt;
      logic        im, co, fp;
      logic [1:0]  pr;
      fxo_ext_s    x;
      logic        nan, inf, big, neg, ae;
      logic [1:0]  cp, cm;
      logic        oe, po;
   } fxo_op_s;
   logic       sys_clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, exc_ack, big;
   logic [3:0] dly = 4'h0;
   logic       ce = 1'b1;
   fxo_op_s    s, d = '0;
   int         num_errors = 0, checks_done = 0;
   logic       wr_valid, wr_undefined, underflow_seen, exc_req, exc_operand_error_flag, exc_overflow_flag;
   fxo_ext_s   wr_data;
   fxo_kind_e  exc_kind;
   logic [7:0] exception_status_byte;
   logic [15:0] saved_command_field;
   logic [31:0] exc_ea, fp_instruction_address_register;
   logic [2:0] fm [3] = '{3'h6, 3'h4, 3'h0};
   always #2 sys_clk = ~sys_clk;
   fxo_seq_model i_seq (.sys_clk, .rstn, .exc_req, .dly, .exc_ack);
   fxo_exc_unit i_dut (.sys_clk, .rstn, .clk_en(ce), .op_valid, .op_cmd(d.cmd),
      .op_iaddr(d.ia), .op_ea(d.ea), .op_dst(d.dst), .op_fmt(d.fmt), .op_is_int_move(d.im),
      .op_can_overflow_flag(d.co), .op_forced_prec(d.fp), .op_prec(d.pr), .op_inter(d.x),
      .op_src_nan(d.nan), .op_src_inf(d.inf), .op_int_too_big(d.big),
      .op_int_most_neg(d.neg), .op_arith_operand_error_flag(d.ae), .ctl_prec(d.cp), .ctl_mode(d.cm),
      .ctl_operand_error_flag_en(d.oe), .ctl_post_overflow_flag_fpreg(d.po), .exc_ack, .wr_valid, .wr_undefined,
      .wr_data, .exception_status_byte, .underflow_seen, .exc_req, .exc_kind, .exc_operand_error_flag,
      .exc_overflow_flag, .exc_ea_valid(), .saved_command_field, .exc_ea,
      .fp_instruction_address_register);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [79:0] e, input logic [79:0] a);
      checks_done++;
      if (a !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, a);
      end
   endtask
   task automatic nw;
      @(posedge sys_clk);
      s = '0;
   endtask
   // issue one op; look just after the taking edge, outputs stand one cycle
   task automatic go;
      d <= s;
      op_valid <= 1'b1;
      @(posedge sys_clk);
      op_valid <= 1'b0;
      #1;
   endtask
   task automatic idle;
      for (int i = 0; i < 40 && exc_req !== 1'b0; i++) @(posedge sys_clk);
      chk("exc_req idle", 0, exc_req);
   endtask
   task automatic test_done;
      if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      test_done;
   end
   initial begin
      s = '0;
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      nw; s.ae = 1'b1; go;
      chk("qnan", {1'b1, 15'h7fff, 64'hffffffffffffffff}, {wr_valid, wr_data[78:0]});
      chk("operand_error_flag flag", 2'h2, {exception_status_byte[5], exc_req});
      nw; s.ae = 1'b1; s.oe = 1'b1; s.cmd = 16'h1234; s.ia = 32'h1000; go;
      chk("posted", 0, {wr_valid, exc_req});
      nw; s.cmd = 16'h5555; go;
      chk("pre kind", {1'b1, FXO_EXC_PRE}, {exc_operand_error_flag, exc_kind});
      chk("frame", {16'h1234, 32'h1000}, {saved_command_field, fp_instruction_address_register});
      idle;
      for (int k = 0; k < 4; k++) begin
         nw; s.im = 1'b1; s.fmt = fm[k % 3]; s.dst = k[0] ? FXO_DST_DREG : FXO_DST_MEM;
         s.ea = 32'h2000 + k; s.ia = 32'h3000 + k; {s.big, s.nan, s.inf, s.neg} = 4'h8 >> k;
         dly <= k[1] ? 4'h6 : 4'h0;
         go;
         chk("int trap", {1'b1, FXO_EXC_POST}, {exc_operand_error_flag, exc_kind});
         if (k[0]) chk("iar", 32'h3000 + k, fp_instruction_address_register);
         else chk("ea", 32'h2000 + k, exc_ea);
         idle;
      end
      for (int m = 0; m < 8; m++) begin
         nw; s.co = 1'b1; s.dst = FXO_DST_MEM; s.fmt = 3'h1; s.cp = 2'h2; s.cm = 2'(m >> 1);
         s.x = {m[0], 15'h4090, 64'h8000000000000000}; go;
         big = m < 2 || m == 5 || m == 6;
         chk("overflow_flag value", {m[0], big ? 15'h7fff : 15'h407e}, wr_data[79:64]);
         chk("overflow_flag store", 2'h3, {wr_undefined, exception_status_byte[4]});
         chk("overflow_flag req", {1'b1, FXO_EXC_POST}, {exc_overflow_flag, exc_kind});
         idle;
      end
      for (int j = 0; j < 2; j++) begin
         nw; s.co = 1'b1; s.dst = FXO_DST_MEM; s.fmt = 3'h1; s.fp = j[0];
         s.x = {1'b0, j[0] ? 15'h4090 : 15'h407d, 64'h8000000000000000}; go;
         chk("no overflow_flag", 0, {exception_status_byte[4], exc_req});
      end
      for (int p = 1; p >= 0; p--) begin
         nw; s.co = 1'b1; s.cp = 2'h1; s.po = p[0]; s.x = {16'h4090, 64'h8000000000000000}; go;
         chk("fpreg overflow_flag", 2'h1, {wr_valid, exception_status_byte[4]});
         if (p == 0) begin
            chk("deferred", 0, exc_req);
            nw;
            go;
         end
         chk("fpreg kind", {1'b1, p ? FXO_EXC_POST : FXO_EXC_PRE}, {exc_overflow_flag, exc_kind});
         idle;
      end
      // word format rounds at extended precision, so the exponent must reach its maximum
      nw; s.co = 1'b1; s.dst = FXO_DST_MEM; s.fmt = 3'h4; s.x = {16'h7fff, 64'h8000000000000000}; go;
      chk("fmt operand_error_flag", 2'h2, {exc_operand_error_flag, exc_overflow_flag});
      idle;
      nw; s.co = 1'b1; s.fmt = 3'h2; s.x = {16'h0000, 64'h8000000000000000}; go;
      chk("tiny", 1, underflow_seen);
      // enable low: an operand error op must leave every state bit alone
      nw; s.ae = 1'b1; ce <= 1'b0; go;
      chk("frozen", 2'h2, {underflow_seen, exception_status_byte[5]});
      ce <= 1'b1;
      test_done;
   end
endmodule
`default_nettype wire
